// ==== core/exec_core.sv ====
// Purpose: Instruction timing sequencer and 8-bit ALU of the core for sector 0 operations.
// Assumes: The decoder presents one decoded operation with its memory byte while ready_o is high.
// Notes:   Results other than the call stack and table pointer are held pending and committed in the last clock of the last instruction cycle.
`timescale 1ns/1ps

module exec_core
   import exec_pkg::*;
(
   input  wire  logic             clk_i,
   input  wire  logic             resetn_i,
   input  wire  logic             issue_i,
   input  exec_pkg::op_t          op_i,
   input  wire  logic [7:0]       mem_addr_i,
   input  wire  logic [7:0]       mem_rdata_i,
   input  wire  logic [7:0]       imm_i,
   input  wire  logic [2:0]       bit_sel_i,
   input  wire  logic [12:0]      target_i,
   input  wire  logic [12:0]      tbl_ptr_i,
   input  wire  logic [15:0]      tbl_data_i,
   output logic                   ready_o,
   output logic                   done_o,
   output logic [7:0]             working_register_o,
   output logic                   zero_flag_o,
   output logic                   carry_flag_o,
   output logic                   nibble_carry_flag_o,
   output logic                   signed_wrap_flag_o,
   output logic                   secondary_carry_flag_o,
   output logic                   extended_zero_flag_o,
   output logic                   mem_we_o,
   output logic [7:0]             mem_addr_o,
   output logic [7:0]             mem_wdata_o,
   output logic [1:0]             mem_sector_o,
   output logic [12:0]            pc_o,
   output logic [12:0]            tbl_addr_o,
   output logic [7:0]             tbl_high_o
);
   import exec_pkg::*;

   typedef struct packed {
      run_t                         run;
      logic                         rdy;
      logic [1:0]                   phase;
      logic [1:0]                   left;
      logic [1:0]                   total;
      op_t                          op;
      logic [7:0]                   w;
      logic [5:0]                   flg;
      logic [12:0]                  pc;
      logic [7:0]                   p_w;
      logic                         p_w_en;
      logic [7:0]                   p_mem;
      logic                         p_mem_en;
      logic [7:0]                   p_addr;
      logic [5:0]                   p_flg;
      logic [5:0]                   p_mask;
      logic [12:0]                  p_pc;
      logic [2:0]                   sp;
      logic [STACK_DEPTH-1:0][12:0] stack;
      logic                         done;
      logic                         we;
      logic [7:0]                   maddr;
      logic [7:0]                   wdata;
      logic [1:0]                   sector;
      logic [12:0]                  taddr;
      logic [7:0]                   thigh;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic   take;

   // Returns {carry into bit 7, signed wrap, nibble carry, carry out, sum}
   function automatic logic [11:0] addf(input logic [7:0] x, input logic [7:0] y, input logic ci);
      logic [4:0] lo;
      logic [7:0] lo7;
      logic [8:0] s9;
      lo  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      lo7 = {1'b0, x[6:0]} + {1'b0, y[6:0]} + {7'h00, ci};
      s9  = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      addf = {lo7[7], lo7[7] ^ s9[8], lo[4], s9[8], s9[7:0]};
   endfunction

   assign take = s_r.rdy & issue_i;

   always_comb begin
      logic [7:0]  a;
      logic [7:0]  m;
      logic [7:0]  res;
      logic [7:0]  bx;
      logic [11:0] sum;
      logic [8:0]  d9;
      logic [5:0]  fl;
      logic [5:0]  mask;
      logic [12:0] pcn;
      logic [12:0] pc1;
      logic [1:0]  ncyc;
      logic        to_w;
      logic        to_mem;
      logic        arith;
      logic        sub;
      logic        chain;
      logic        skip;
      a      = s_r.w;
      m      = mem_rdata_i;
      res    = 8'h00;
      bx     = m;
      sum    = 12'h000;
      d9     = 9'h000;
      fl     = s_r.flg;
      mask   = MASK_NONE;
      pc1    = s_r.pc + PC_STEP;
      pcn    = pc1;
      ncyc   = ICYC_ONE;
      to_w   = 1'b0;
      to_mem = 1'b0;
      arith  = 1'b0;
      sub    = 1'b0;
      skip   = 1'b0;
      chain  = op_i inside {OP_ADDC_W, OP_ADDC_MEM, OP_BORROW_IW, OP_BORROW_MW, OP_BORROW_MEM};
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      s_nxt.we   = 1'b0;

      unique case (op_i)
         OP_NOP: begin
         end
         OP_LOAD_W: begin
            res  = m;
            to_w = 1'b1;
         end
         OP_STORE_W: begin
            res    = a;
            to_mem = 1'b1;
         end
         OP_IMM_W: begin
            res  = imm_i;
            to_w = 1'b1;
         end
         OP_ADD_MW, OP_ADDC_W: begin
            arith = 1'b1;
            to_w  = 1'b1;
         end
         OP_ADD_IW: begin
            arith = 1'b1;
            bx    = imm_i;
            to_w  = 1'b1;
         end
         OP_SUM_TO_MEM, OP_ADDC_MEM: begin
            arith  = 1'b1;
            to_mem = 1'b1;
         end
         OP_SUB_IW, OP_BORROW_IW: begin
            arith = 1'b1;
            sub   = 1'b1;
            bx    = imm_i;
            to_w  = 1'b1;
         end
         OP_SUB_MW, OP_BORROW_MW: begin
            arith = 1'b1;
            sub   = 1'b1;
            to_w  = 1'b1;
         end
         OP_DIFF_TO_MEM, OP_BORROW_MEM: begin
            arith  = 1'b1;
            sub    = 1'b1;
            to_mem = 1'b1;
         end
         OP_DECIMAL_FIXUP: begin
            d9 = {1'b0, a};
            if (a[3:0] > BCD_LIMIT || s_r.flg[F_NIBBLE]) begin
               d9 = d9 + BCD_LOW_FIX;
            end
            if (d9[7:4] > BCD_LIMIT || s_r.flg[F_CARRY] || d9[8]) begin
               d9 = d9 + BCD_HIGH_FIX;
            end
            res         = d9[7:0];
            fl[F_CARRY] = s_r.flg[F_CARRY] | d9[8];
            mask        = MASK_CARRY;
            to_mem      = 1'b1;
         end
         OP_AND_W, OP_AND_MEM: res = a & m;
         OP_OR_W, OP_OR_MEM:   res = a | m;
         OP_XOR_W, OP_XOR_MEM: res = a ^ m;
         OP_AND_IW:            res = a & imm_i;
         OP_OR_IW:             res = a | imm_i;
         OP_XOR_IW:            res = a ^ imm_i;
         OP_INVERT_MEM, OP_INVERT_W: res = ~m;
         OP_INC_W, OP_INC_MEM:       res = m + 8'h01;
         OP_STEP_DOWN_W, OP_STEP_DOWN_MEM: res = m - 8'h01;
         OP_ROR_W, OP_ROR_MEM: res = {m[0], m[7:1]};
         OP_ROL_W, OP_ROL_MEM: res = {m[6:0], m[7]};
         OP_ROR_C_W, OP_ROR_C_MEM: begin
            res         = {s_r.flg[F_CARRY], m[7:1]};
            fl[F_CARRY] = m[0];
            mask        = MASK_CARRY;
         end
         OP_ROL_C_W, OP_ROL_C_MEM: begin
            res         = {m[6:0], s_r.flg[F_CARRY]};
            fl[F_CARRY] = m[7];
            mask        = MASK_CARRY;
         end
         OP_BIT_ZEROING, OP_BIT_SET: begin
            res            = m;
            res[bit_sel_i] = (op_i == OP_BIT_SET);
            to_mem         = 1'b1;
         end
         OP_SKIP_ZERO:     skip = (m == 8'h00);
         OP_SKIP_NZ:       skip = (m != 8'h00);
         OP_SKIP_BIT_ZERO: skip = ~m[bit_sel_i];
         OP_SKIP_BIT_NZ:   skip = m[bit_sel_i];
         OP_SKIP_INC_ZERO, OP_SKIP_DOWN_ZERO: begin
            res    = (op_i == OP_SKIP_INC_ZERO) ? m + 8'h01 : m - 8'h01;
            skip   = (res == 8'h00);
            to_mem = 1'b1;
         end
         OP_BRANCH: begin
            pcn  = target_i;
            ncyc = ICYC_TWO;
         end
         OP_CALL: begin
            // The stack moves only on the take edge; op_i may stay on the bus for many clocks
            if (take) begin
               s_nxt.stack[s_r.sp] = pc1;
               s_nxt.sp            = s_r.sp + 3'h1;
            end
            pcn                 = target_i;
            ncyc                = ICYC_TWO;
         end
         OP_SUB_EXIT: begin
            if (take) begin
               s_nxt.sp = s_r.sp - 3'h1;
            end
            pcn      = s_r.stack[s_r.sp - 3'h1];
            ncyc     = ICYC_TWO;
         end
         OP_TABLE_READ: begin
            to_mem = 1'b1;
            ncyc   = ICYC_TWO;
         end
      endcase

      // Destination of the logic, invert, increment and rotate groups
      if (op_i inside {OP_AND_W, OP_OR_W, OP_XOR_W, OP_AND_IW, OP_OR_IW, OP_XOR_IW,
                       OP_INVERT_W, OP_INC_W, OP_STEP_DOWN_W, OP_ROR_W, OP_ROL_W,
                       OP_ROR_C_W, OP_ROL_C_W}) begin
         to_w = 1'b1;
      end
      if (op_i inside {OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM, OP_INVERT_MEM, OP_INC_MEM,
                       OP_STEP_DOWN_MEM, OP_ROR_MEM, OP_ROL_MEM, OP_ROR_C_MEM,
                       OP_ROL_C_MEM}) begin
         to_mem = 1'b1;
      end
      if (op_i inside {OP_AND_W, OP_OR_W, OP_XOR_W, OP_AND_IW, OP_OR_IW, OP_XOR_IW,
                       OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM, OP_INVERT_W, OP_INVERT_MEM,
                       OP_INC_W, OP_INC_MEM, OP_STEP_DOWN_W, OP_STEP_DOWN_MEM}) begin
         mask = MASK_ZERO;
      end

      // Subtraction is addition of the inverted operand; carry set means no borrow
      if (arith) begin
         sum = addf(a, sub ? ~bx : bx, chain ? s_r.flg[F_CARRY] : sub);
         res = sum[7:0];
         fl[F_CARRY]  = sum[8];
         fl[F_NIBBLE] = sum[9];
         fl[F_WRAP]   = sum[10];
         fl[F_SECOND] = sum[11];
         fl[F_EXTZ]   = (res == 8'h00) & (~chain | s_r.flg[F_EXTZ]);
         mask         = sub ? MASK_SUB : MASK_ADD;
      end
      fl[F_ZERO] = (res == 8'h00);

      // A write into the low program counter byte is a jump
      if (to_mem && mem_addr_i == PCL_ADDR) begin
         pcn  = {s_r.pc[12:8], res};
         ncyc = ncyc + 2'h1;
      end
      if (skip) begin
         pcn  = s_r.pc + PC_SKIP_STEP;
         ncyc = ncyc + 2'h1;
      end

      if (take) begin
         s_nxt.run      = ST_EXEC;
         s_nxt.rdy      = 1'b0;
         s_nxt.phase    = PHASE_FIRST;
         s_nxt.left     = ncyc - 2'h1;
         s_nxt.total    = ncyc;
         s_nxt.op       = op_i;
         s_nxt.p_w      = res;
         s_nxt.p_w_en   = to_w;
         s_nxt.p_mem    = res;
         s_nxt.p_mem_en = to_mem;
         s_nxt.p_addr   = mem_addr_i;
         s_nxt.p_flg    = fl;
         s_nxt.p_mask   = mask;
         s_nxt.p_pc     = pcn;
         if (op_i == OP_TABLE_READ) begin
            s_nxt.taddr = tbl_ptr_i;
         end
      end else if (s_r.run == ST_EXEC) begin
         s_nxt.phase = s_r.phase + 2'h1;
         if (s_r.phase == PHASE_LAST) begin
            s_nxt.left = s_r.left - 2'h1;
         end
         if (s_r.phase == PHASE_LAST && s_r.left == 2'h0) begin
            s_nxt.run    = ST_IDLE;
            s_nxt.rdy    = 1'b1;
            s_nxt.done   = 1'b1;
            s_nxt.flg    = (s_r.flg & ~s_r.p_mask) | (s_r.p_flg & s_r.p_mask);
            s_nxt.pc     = s_r.p_pc;
            s_nxt.we     = s_r.p_mem_en;
            s_nxt.maddr  = s_r.p_addr;
            s_nxt.wdata  = s_r.p_mem;
            s_nxt.sector = SECTOR_ZERO;
            if (s_r.p_w_en) begin
               s_nxt.w = s_r.p_w;
            end
            // Table word is sampled only now, seven clocks after the pointer went out (eleven when the target is PCL)
            if (s_r.op == OP_TABLE_READ) begin
               s_nxt.wdata = tbl_data_i[7:0];
               s_nxt.thigh = tbl_data_i[15:8];
               if (s_r.p_addr == PCL_ADDR) begin
                  s_nxt.pc = {s_r.pc[12:8], tbl_data_i[7:0]};
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s_r        <= '0;
         s_r.run    <= ST_IDLE;
         s_r.rdy    <= 1'b1;
         s_r.w      <= W_RESET;
         s_r.flg    <= FLAGS_RESET;
         s_r.pc     <= PC_RESET;
         s_r.sector <= SECTOR_ZERO;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ready_o                = s_r.rdy;
   assign done_o                 = s_r.done;
   assign working_register_o     = s_r.w;
   assign zero_flag_o            = s_r.flg[F_ZERO];
   assign carry_flag_o           = s_r.flg[F_CARRY];
   assign nibble_carry_flag_o    = s_r.flg[F_NIBBLE];
   assign signed_wrap_flag_o     = s_r.flg[F_WRAP];
   assign secondary_carry_flag_o = s_r.flg[F_SECOND];
   assign extended_zero_flag_o   = s_r.flg[F_EXTZ];
   assign mem_we_o               = s_r.we;
   assign mem_addr_o             = s_r.maddr;
   assign mem_wdata_o            = s_r.wdata;
   assign mem_sector_o           = s_r.sector;
   assign pc_o                   = s_r.pc;
   assign tbl_addr_o             = s_r.taddr;
   assign tbl_high_o             = s_r.thigh;

   // Helper: clocks since the operation was taken
   logic [3:0] span_r;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         span_r <= 4'h0;
      end else if (take) begin
         span_r <= 4'h0;
      end else if (s_r.run == ST_EXEC) begin
         span_r <= span_r + 4'h1;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_take(op_t o);
      take && op_i == o;
   endsequence

   // Committed registers are seen by the assertions one clock after the commit edge
   sequence s_one_icyc;
      !done_o [*3] ##1 done_o;
   endsequence

   AST_ICYC_CLOCKS: assert property (done_o |-> span_r == {s_r.total, 2'b00} - 4'h1)
      else $error("instruction did not last four clocks per cycle");

   AST_PLAIN_ONE: assert property (s_take(OP_ADD_MW) |-> ##1 s_one_icyc)
      else $error("plain add did not finish in one cycle");

   AST_BRANCH_TWO: assert property (s_take(OP_BRANCH) |-> ##1 !done_o [*7] ##1
      (done_o && pc_o == $past(target_i, 8)))
      else $error("branch did not take two cycles to its target");

   AST_PCL_EXTRA: assert property (s_take(OP_STORE_W) ##0 mem_addr_i == PCL_ADDR |-> ##8
      (done_o && pc_o[7:0] == $past(working_register_o, 8)))
      else $error("low program counter write did not take the extra cycle");

   AST_SKIP_TAKEN: assert property (s_take(OP_SKIP_ZERO) ##0 mem_rdata_i == 8'h00 |-> ##8
      (done_o && pc_o == $past(pc_o, 8) + PC_SKIP_STEP))
      else $error("taken skip wrong in timing or address");

   AST_SKIP_NOT: assert property (s_take(OP_SKIP_NZ) ##0 mem_rdata_i == 8'h00 |-> ##4
      (done_o && pc_o == $past(pc_o, 4) + PC_STEP))
      else $error("untaken skip wrong in timing or address");

   // Only a return taken right after the call's commit is checked here
   property p_return;
      s_take(OP_CALL) ##8 s_take(OP_SUB_EXIT) |-> ##8 (done_o && pc_o == $past(pc_o, 16) + PC_STEP);
   endproperty
   AST_RETURN: assert property (p_return)
      else $error("return did not resume after the call");

   AST_ADD_CARRY: assert property (s_take(OP_ADD_IW) |-> ##4
      ({carry_flag_o, working_register_o} == {1'b0, $past(working_register_o, 4)} + {1'b0, $past(imm_i, 4)}))
      else $error("immediate add gave wrong sum or carry");

   AST_SUB_MEM: assert property (s_take(OP_DIFF_TO_MEM) ##0 mem_addr_i != PCL_ADDR |-> ##4
      (mem_we_o && mem_wdata_o == $past(working_register_o, 4) - $past(mem_rdata_i, 4) &&
       extended_zero_flag_o == (mem_wdata_o == 8'h00)))
      else $error("memory subtract wrong");

   AST_LOGIC_ZERO: assert property (s_take(OP_AND_W) |-> ##4
      (working_register_o == ($past(working_register_o, 4) & $past(mem_rdata_i, 4)) &&
       $stable(carry_flag_o) && zero_flag_o == (working_register_o == 8'h00)))
      else $error("logic op touched wrong flags or result");

   AST_ROT_FLAGS: assert property (s_take(OP_ROR_W) |-> ##4
      (working_register_o == {$past(mem_rdata_i[0], 4), $past(mem_rdata_i[7:1], 4)} &&
       $stable({zero_flag_o, carry_flag_o, signed_wrap_flag_o})))
      else $error("plain rotate changed a flag or gave wrong value");

   AST_BIT_SET: assert property (s_take(OP_BIT_SET) ##0 mem_addr_i != PCL_ADDR |-> ##4
      (mem_we_o && mem_wdata_o == ($past(mem_rdata_i, 4) | (8'h01 << $past(bit_sel_i, 4)))))
      else $error("bit set disturbed other bits");

   AST_SECTOR: assert property (mem_we_o |-> mem_sector_o == SECTOR_ZERO)
      else $error("write outside sector zero");

endmodule

// ==== core/exec_pkg.sv ====
// Purpose: Shared constants and types of the execution timing and ALU datapath.
// Assumes: 8-bit data, 13-bit program counter, sector 0 data addressing only.
// Notes:   All timing is in system clocks; one instruction cycle is four of them.
package exec_pkg;

   // Instruction cycle framing
   localparam int unsigned CLKS_PER_ICYC = 4;
   localparam logic [1:0]  PHASE_FIRST   = 2'h1;
   localparam logic [1:0]  PHASE_LAST    = 2'h3;
   localparam logic [1:0]  ICYC_ONE      = 2'h1;
   localparam logic [1:0]  ICYC_TWO      = 2'h2;

   // Addresses and reset values
   localparam logic [7:0]  PCL_ADDR      = 8'h06;
   localparam logic [1:0]  SECTOR_ZERO   = 2'h0;
   localparam logic [12:0] PC_RESET      = 13'h0000;
   localparam logic [12:0] PC_STEP       = 13'h0001;
   localparam logic [12:0] PC_SKIP_STEP  = 13'h0002;
   localparam logic [7:0]  W_RESET       = 8'h00;
   localparam logic [5:0]  FLAGS_RESET   = 6'h00;
   localparam int unsigned STACK_DEPTH   = 8;

   // Flag positions
   localparam int unsigned F_ZERO        = 0;
   localparam int unsigned F_CARRY       = 1;
   localparam int unsigned F_NIBBLE      = 2;
   localparam int unsigned F_WRAP        = 3;
   localparam int unsigned F_SECOND      = 4;
   localparam int unsigned F_EXTZ        = 5;

   // Flag update masks
   localparam logic [5:0]  MASK_NONE     = 6'h00;
   localparam logic [5:0]  MASK_ZERO     = 6'h01;
   localparam logic [5:0]  MASK_CARRY    = 6'h02;
   localparam logic [5:0]  MASK_ADD      = 6'h1f;
   localparam logic [5:0]  MASK_SUB      = 6'h3f;

   // Decimal adjust
   localparam logic [3:0]  BCD_LIMIT     = 4'h9;
   localparam logic [8:0]  BCD_LOW_FIX   = 9'h006;
   localparam logic [8:0]  BCD_HIGH_FIX  = 9'h060;

   typedef enum logic [5:0] {
      OP_NOP, OP_LOAD_W, OP_STORE_W, OP_IMM_W,
      OP_ADD_MW, OP_ADD_IW, OP_SUM_TO_MEM, OP_ADDC_W, OP_ADDC_MEM,
      OP_SUB_IW, OP_SUB_MW, OP_DIFF_TO_MEM, OP_BORROW_IW, OP_BORROW_MW, OP_BORROW_MEM,
      OP_DECIMAL_FIXUP,
      OP_AND_W, OP_OR_W, OP_XOR_W, OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM,
      OP_AND_IW, OP_OR_IW, OP_XOR_IW,
      OP_INVERT_MEM, OP_INVERT_W, OP_INC_W, OP_INC_MEM, OP_STEP_DOWN_W, OP_STEP_DOWN_MEM,
      OP_ROR_W, OP_ROR_MEM, OP_ROR_C_W, OP_ROR_C_MEM,
      OP_ROL_W, OP_ROL_MEM, OP_ROL_C_W, OP_ROL_C_MEM,
      OP_BIT_ZEROING, OP_BIT_SET,
      OP_SKIP_ZERO, OP_SKIP_NZ, OP_SKIP_BIT_ZERO, OP_SKIP_BIT_NZ,
      OP_SKIP_INC_ZERO, OP_SKIP_DOWN_ZERO,
      OP_BRANCH, OP_CALL, OP_SUB_EXIT, OP_TABLE_READ
   } op_t;

   typedef enum logic {ST_IDLE, ST_EXEC} run_t;

endpackage

// ==== verification/mcu_core_exec_timing_alu_tb.sv ====
// Purpose: Self-checking bench for the execution timing sequencer and ALU.
// Assumes: Rows run in order; each expected state follows from the rows before it.
// Notes:   Issue stays high two clocks past the take, so every row also offers a request that must be ignored.
`timescale 1ns/1ps
module mcu_core_exec_timing_alu_tb;
   import exec_pkg::*;
   typedef struct {
      op_t op; logic [7:0] opd; logic [2:0] bs; logic [1:0] n;
      logic [7:0] w; logic [5:0] f; logic [8:0] wd; logic [12:0] pc;
   } row_t;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        issue_i = 1'b0;
   op_t         op_i = OP_NOP;
   logic [7:0]  mem_addr_i = 8'h10, mem_rdata_i = 8'h00, imm_i = 8'h00, mem_addr_o, mem_wdata_o, tbl_high_o;
   logic [2:0]  bit_sel_i = 3'h0;
   logic [12:0] target_i = 13'h0000, pc_o, tbl_addr_o;
   logic [7:0]  working_register_o;
   logic [1:0]  mem_sector_o;
   logic        ready_o, done_o, mem_we_o, zf, cf, nf, vf, sf, ef;
   int          fails = 0;
   int          n_tests = 0;
   wire  [5:0]  flags = {ef, sf, vf, nf, cf, zf};
   row_t        rows[27] = '{
      '{OP_IMM_W,8'h7f,3'h0,2'h1,8'h7f,6'h00,9'h000,13'h001}, '{OP_ADD_IW,8'h01,3'h0,2'h1,8'h80,6'h1c,9'h000,13'h002},
      '{OP_ADD_MW,8'h80,3'h0,2'h1,8'h00,6'h0b,9'h000,13'h003}, '{OP_ADDC_W,8'h01,3'h0,2'h1,8'h02,6'h00,9'h000,13'h004},
      '{OP_SUB_IW,8'h01,3'h0,2'h1,8'h01,6'h16,9'h000,13'h005}, '{OP_BORROW_IW,8'h01,3'h0,2'h1,8'h00,6'h17,9'h000,13'h006},
      '{OP_IMM_W,8'ha5,3'h0,2'h1,8'ha5,6'h17,9'h000,13'h007}, '{OP_OR_IW,8'h5a,3'h0,2'h1,8'hff,6'h16,9'h000,13'h008},
      '{OP_ROL_C_W,8'h01,3'h0,2'h1,8'h03,6'h14,9'h000,13'h009}, '{OP_ROR_W,8'h01,3'h0,2'h1,8'h80,6'h14,9'h000,13'h00a},
      '{OP_INVERT_W,8'hff,3'h0,2'h1,8'h00,6'h15,9'h000,13'h00b}, '{OP_INC_W,8'h7f,3'h0,2'h1,8'h80,6'h14,9'h000,13'h00c},
      '{OP_SUM_TO_MEM,8'h80,3'h0,2'h1,8'h80,6'h0b,9'h100,13'h00d},
      '{OP_BIT_SET,8'h00,3'h7,2'h1,8'h80,6'h0b,9'h180,13'h00e},
      '{OP_BIT_ZEROING,8'hff,3'h0,2'h1,8'h80,6'h0b,9'h1fe,13'h00f},
      '{OP_DIFF_TO_MEM,8'h80,3'h0,2'h1,8'h80,6'h37,9'h100,13'h010},
      '{OP_ROR_C_MEM,8'h02,3'h0,2'h1,8'h80,6'h35,9'h181,13'h011},
      '{OP_DECIMAL_FIXUP,8'h00,3'h0,2'h1,8'h80,6'h35,9'h186,13'h012},
      '{OP_STORE_W,8'h00,3'h0,2'h2,8'h80,6'h35,9'h180,13'h080}, '{OP_BRANCH,8'h00,3'h0,2'h2,8'h80,6'h35,9'h000,13'h123},
      '{OP_CALL,8'h00,3'h0,2'h2,8'h80,6'h35,9'h000,13'h050}, '{OP_SKIP_ZERO,8'h00,3'h0,2'h2,8'h80,6'h35,9'h000,13'h052},
      '{OP_SKIP_NZ,8'h00,3'h0,2'h1,8'h80,6'h35,9'h000,13'h053}, '{OP_SKIP_BIT_NZ,8'h80,3'h7,2'h2,8'h80,6'h35,9'h000,13'h055},
      '{OP_SUB_EXIT,8'h00,3'h0,2'h2,8'h80,6'h35,9'h000,13'h124}, '{OP_TABLE_READ,8'h00,3'h0,2'h2,8'h80,6'h35,9'h1ef,13'h125},
      '{OP_AND_W,8'hf0,3'h0,2'h1,8'h80,6'h34,9'h000,13'h126}};

   exec_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .issue_i(issue_i), .op_i(op_i), .mem_addr_i(mem_addr_i),
      .mem_rdata_i(mem_rdata_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i), .target_i(target_i), .tbl_ptr_i(13'h00aa),
      .tbl_data_i(16'hbeef), .ready_o(ready_o), .done_o(done_o), .working_register_o(working_register_o),
      .zero_flag_o(zf), .carry_flag_o(cf), .nibble_carry_flag_o(nf), .signed_wrap_flag_o(vf),
      .secondary_carry_flag_o(sf), .extended_zero_flag_o(ef), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_sector_o(mem_sector_o), .pc_o(pc_o), .tbl_addr_o(tbl_addr_o),
      .tbl_high_o(tbl_high_o));

   initial forever #4 clk_i = ~clk_i;

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic run(input row_t r);
      int k;
      @(posedge clk_i);
      op_i        <= r.op;
      mem_rdata_i <= r.opd;
      imm_i       <= r.opd;
      bit_sel_i   <= r.bs;
      mem_addr_i  <= (r.op == OP_STORE_W) ? PCL_ADDR : 8'h10;
      target_i    <= (r.op == OP_CALL) ? 13'h0050 : 13'h0123;
      issue_i     <= 1'b1;
      // Held past the take on purpose: the core is busy and must ignore it
      repeat (3) @(posedge clk_i);
      issue_i     <= 1'b0;
      k = 2;
      while (done_o !== 1'b1 && k < 16) begin
         @(posedge clk_i);
         k++;
         @(negedge clk_i);
      end
      if (k >= 16) begin
         fails++;
         final_report();
      end
      chk(13'(k), 13'(4 * r.n - 1), "cycles");
      chk(ready_o, 1'b1, "ready");
      chk(working_register_o, r.w, "working");
      chk(flags, r.f, "flags");
      chk(mem_we_o, r.wd[8], "write");
      if (r.wd[8]) chk(mem_wdata_o, r.wd[7:0], "wdata");
      if (r.wd[8]) chk(mem_addr_o, (r.op == OP_STORE_W) ? PCL_ADDR : 8'h10, "waddr");
      chk(pc_o, r.pc, "pc");
      chk(mem_sector_o, SECTOR_ZERO, "sector");
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(negedge clk_i);
      chk(ready_o, 1'b1, "reset ready");
      chk(pc_o, PC_RESET, "reset pc");
      foreach (rows[i]) run(rows[i]);
      chk(tbl_addr_o, 13'h00aa, "table address");
      chk(tbl_high_o, 8'hbe, "table high");
      // Call and return back to back: the return is taken on the edge after the call commits
      @(posedge clk_i);
      op_i     <= OP_CALL;
      issue_i  <= 1'b1;
      repeat (8) @(posedge clk_i);
      op_i     <= OP_SUB_EXIT;
      @(posedge clk_i);
      issue_i  <= 1'b0;
      repeat (7) @(posedge clk_i);
      @(negedge clk_i);
      chk(done_o, 1'b1, "return done");
      chk(pc_o, 13'h127, "return pc");
      // Reset in mid-instruction must abandon it and clear the state
      @(posedge clk_i);
      op_i     <= OP_BRANCH;
      issue_i  <= 1'b1;
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b0;
      issue_i  <= 1'b0;
      @(posedge clk_i);
      resetn_i <= 1'b1;
      @(negedge clk_i);
      chk({done_o, ready_o}, 2'b01, "mid reset handshake");
      chk(pc_o, PC_RESET, "mid reset pc");
      chk(working_register_o, W_RESET, "mid reset working");
      chk(flags, FLAGS_RESET, "mid reset flags");
      final_report();
   end
endmodule
